/* verilog/link_evt_pkg.sv */
// Purpose: Shared constants for the link event, prescaler and capture bank
// Assumes: 32-bit register data, byte offsets on a 20-bit address
// Notes: Offsets from 12020h on are local additions for control and interrupts
package link_evt_pkg;
  localparam int NPORT = 4;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 32;
  localparam int PAYLOAD_W = 128;
  localparam int NWORD = 4;
  localparam int DIV_W = 8;
  localparam int RST_SEQ_LEN = 4;
  localparam logic [1:0] RST_SEQ_LAST = 2'(RST_SEQ_LEN - 1);

  localparam logic [19:0] OFF_DIV = 20'h12008;
  localparam logic [19:0] OFF_PW0 = 20'h12010;
  localparam logic [19:0] OFF_PW1 = 20'h12014;
  localparam logic [19:0] OFF_PW2 = 20'h12018;
  localparam logic [19:0] OFF_PW3 = 20'h1201C;
  localparam logic [19:0] OFF_CFG = 20'h12020;
  localparam logic [19:0] OFF_IRQ_STAT = 20'h12024;
  localparam logic [19:0] OFF_IRQ_CLR = 20'h12028;
  localparam logic [19:0] OFF_IRQ_EN = 20'h1202C;

  // Operating config bit positions
  localparam int CFG_MCAST_EN = 5;
  localparam int CFG_MCAST_FLAG = 4;
  localparam int CFG_RST_EN = 3;
  localparam int CFG_RST_FLAG = 2;
  localparam int CFG_PORTWRITE_IN_INT_ENABLE = 1;
  localparam int CFG_PW_FLAG = 0;

  // Event index in status, clear and enable registers
  localparam int EV_PW = 0;
  localparam int EV_RST = 1;
  localparam int EV_MCAST = 2;
  localparam int NEV = 3;

  localparam logic [7:0] DIV_RESET = 8'h01;
  localparam logic [31:0] CAPT_RESET = 32'h00000000;
  localparam logic [2:0] EV_RESET = 3'h0;
endpackage

/* verilog/link_evt_if.sv */
// Purpose: Carries divider, tick and reset symbol traffic between submodules
// Assumes: One clock domain
// Notes: ctrl is the register bank end
`timescale 1ns/1ns
interface link_evt_if;
  logic [7:0] div;
  logic tick;
  logic [3:0] sym_valid;
  logic [3:0] sym_reset;
  logic [3:0] rst_seen;
  modport ctrl (output div, sym_valid, sym_reset, input tick, rst_seen);
  modport pre (input div, output tick);
  modport rcnt (input sym_valid, sym_reset, output rst_seen);
endinterface

/* verilog/tick_prescaler.sv */
// Purpose: Divides the system clock into a common timer tick
// Assumes: Divider value N gives one tick every N+1 clocks
// Notes: A lowered divider takes effect at once
`timescale 1ns/1ns
module tick_prescaler
  import link_evt_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Divider and tick
  link_evt_if.pre evt
);
  logic [7:0] cnt_q;
  logic tick_q;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 8'h00;
      tick_q <= 1'b0;
    end
    else if (cnt_q >= evt.div)
    begin
      cnt_q <= 8'h00;
      tick_q <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 8'h01;
      tick_q <= 1'b0;
    end
  end

  assign evt.tick = tick_q;

  property p_tick_gap;
    @(posedge clk_sys) disable iff (!rst_n)
    (tick_q && evt.div != 8'h00) |=> !tick_q;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick came too soon");

  property p_tick_due;
    @(posedge clk_sys) disable iff (!rst_n)
    (cnt_q == evt.div) |=> tick_q;
  endproperty
  a_tick_due: assert property (p_tick_due) else $error("tick missing");
endmodule

/* verilog/rst_seq_counter.sv */
// Purpose: Detects four reset control symbols in a row on each port
// Assumes: Non-reset symbols break the run, idle cycles do not
// Notes: Counter restarts after each detected run
`timescale 1ns/1ns
module rst_seq_counter
  import link_evt_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Symbols in, detections out
  link_evt_if.rcnt evt
);
  logic [1:0] cnt_q [NPORT];
  logic [3:0] hit_q;

  for (genvar p = 0; p < NPORT; p++)
  begin : g_port
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
      begin
        cnt_q[p] <= 2'h0;
        hit_q[p] <= 1'b0;
      end
      else if (evt.sym_valid[p] && evt.sym_reset[p])
      begin
        hit_q[p] <= (cnt_q[p] == RST_SEQ_LAST);
        cnt_q[p] <= (cnt_q[p] == RST_SEQ_LAST) ? 2'h0 : cnt_q[p] + 2'h1;
      end
      else
      begin
        hit_q[p] <= 1'b0;
        if (evt.sym_valid[p])
          cnt_q[p] <= 2'h0;
      end
    end
  end

  assign evt.rst_seen = hit_q;

  sequence s_rst0;
    evt.sym_valid[0] && evt.sym_reset[0];
  endsequence

  property p_four_rst;
    @(posedge clk_sys) disable iff (!rst_n)
    (cnt_q[0] == 2'h0 && evt.sym_valid[0] && evt.sym_reset[0]) ##1 s_rst0 [*3] |=> hit_q[0];
  endproperty
  a_four_rst: assert property (p_four_rst) else $error("four resets not seen");

  property p_break;
    @(posedge clk_sys) disable iff (!rst_n)
    (evt.sym_valid[0] && !evt.sym_reset[0]) |=> (cnt_q[0] == 2'h0 && !hit_q[0]);
  endproperty
  a_break: assert property (p_break) else $error("run not broken");
endmodule

/* verilog/link_evt_bank.sv */
// Purpose: Sticky link events, interrupts, timer prescaler and port-write capture
// Assumes: Register strobes one cycle long, read data valid the cycle after
// Notes: Status, clear and enable registers alias the config flag and enable bits
`timescale 1ns/1ns
module link_evt_bank
  import link_evt_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [19:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  // Received control symbols, one lane per port
  input wire logic [3:0] sym_valid,
  input wire logic [3:0] sym_reset,
  input wire logic [3:0] sym_mcast,
  // Incoming port-write
  input wire logic pw_valid,
  input wire logic [127:0] pw_payload,
  // Interrupts and tick
  output logic mcast_int_out,
  output logic rst_int_out,
  output logic portwrite_in_int_out,
  output logic int_out,
  output logic timer_tick
);
  link_evt_if evt ();

  logic [7:0] tick_divider_value_q;
  logic [2:0] flag_q;
  logic [2:0] flag_d;
  logic [2:0] en_q;
  logic [2:0] en_d;
  logic [2:0] ev_in;
  logic [2:0] clr;
  logic [31:0] word_q [NWORD];
  logic [31:0] rd_data_q;
  logic [31:0] rd_mux;
  logic int_q;
  logic cfg_wr;

  tick_prescaler u_pre (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .evt(evt.pre)
  );

  rst_seq_counter u_rcnt (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .evt(evt.rcnt)
  );

  assign evt.div = tick_divider_value_q;
  assign evt.sym_valid = sym_valid;
  assign evt.sym_reset = sym_reset;

  assign cfg_wr = wr_en && (addr == OFF_CFG);

  // Events and write-one clears from either the config or the clear register
  always_comb
  begin
    ev_in = 3'h0;
    ev_in[EV_MCAST] = |(sym_valid & sym_mcast);
    ev_in[EV_RST] = |evt.rst_seen;
    ev_in[EV_PW] = pw_valid;
    clr = 3'h0;
    if (cfg_wr)
    begin
      clr[EV_MCAST] = wr_data[CFG_MCAST_FLAG];
      clr[EV_RST] = wr_data[CFG_RST_FLAG];
      clr[EV_PW] = wr_data[CFG_PW_FLAG];
    end
    else if (wr_en && addr == OFF_IRQ_CLR)
      clr = wr_data[2:0];
    flag_d = ev_in | (flag_q & ~clr);
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      flag_q <= EV_RESET;
    else
      flag_q <= flag_d;
  end

  // Enables from either the config or the enable register
  always_comb
  begin
    en_d = en_q;
    if (cfg_wr)
    begin
      en_d[EV_MCAST] = wr_data[CFG_MCAST_EN];
      en_d[EV_RST] = wr_data[CFG_RST_EN];
      en_d[EV_PW] = wr_data[CFG_PORTWRITE_IN_INT_ENABLE];
    end
    else if (wr_en && addr == OFF_IRQ_EN)
      en_d = wr_data[2:0];
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      en_q <= EV_RESET;
    else
      en_q <= en_d;
  end

  // Combined level interrupt follows enabled flags with no extra lag
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      int_q <= 1'b0;
    else
      int_q <= |(flag_d & en_d);
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      tick_divider_value_q <= DIV_RESET;
    else if (wr_en && addr == OFF_DIV)
      tick_divider_value_q <= wr_data[7:0];
  end

  for (genvar k = 0; k < NWORD; k++)
  begin : g_capt
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
        word_q[k] <= CAPT_RESET;
      else if (pw_valid)
        word_q[k] <= pw_payload[32*k +: 32];
    end
  end

  always_comb
  begin
    rd_mux = 32'h00000000;
    case (addr)
      OFF_DIV: rd_mux = {24'h000000, tick_divider_value_q};
      OFF_PW0: rd_mux = word_q[0];
      OFF_PW1: rd_mux = word_q[1];
      OFF_PW2: rd_mux = word_q[2];
      OFF_PW3: rd_mux = word_q[3];
      OFF_CFG:
      begin
        rd_mux[CFG_MCAST_EN] = en_q[EV_MCAST];
        rd_mux[CFG_MCAST_FLAG] = flag_q[EV_MCAST];
        rd_mux[CFG_RST_EN] = en_q[EV_RST];
        rd_mux[CFG_RST_FLAG] = flag_q[EV_RST];
        rd_mux[CFG_PORTWRITE_IN_INT_ENABLE] = en_q[EV_PW];
        rd_mux[CFG_PW_FLAG] = flag_q[EV_PW];
      end
      OFF_IRQ_STAT: rd_mux = {29'h00000000, flag_q};
      OFF_IRQ_EN: rd_mux = {29'h00000000, en_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rd_data_q <= 32'h00000000;
    else if (rd_en)
      rd_data_q <= rd_mux;
    else
      rd_data_q <= 32'h00000000;
  end

  assign rd_data = rd_data_q;
  assign mcast_int_out = flag_q[EV_MCAST];
  assign rst_int_out = flag_q[EV_RST];
  assign portwrite_in_int_out = flag_q[EV_PW];
  assign int_out = int_q;
  assign timer_tick = evt.tick;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  property p_mcast_int;
    (|(sym_valid & sym_mcast) && en_q[EV_MCAST] && !wr_en) |=> (int_out && mcast_int_out);
  endproperty
  a_mcast_int: assert property (p_mcast_int) else $error("multicast interrupt missing");

  property p_mcast_hold;
    (mcast_int_out && !(cfg_wr && wr_data[CFG_MCAST_FLAG]) && !(wr_en && addr == OFF_IRQ_CLR)) |=> mcast_int_out;
  endproperty
  a_mcast_hold: assert property (p_mcast_hold) else $error("multicast flag dropped");

  property p_rst_int;
    (|evt.rst_seen && en_q[EV_RST] && !wr_en) |=> (int_out && rst_int_out);
  endproperty
  a_rst_int: assert property (p_rst_int) else $error("reset interrupt missing");

  property p_rst_flag;
    |evt.rst_seen |=> rst_int_out;
  endproperty
  a_rst_flag: assert property (p_rst_flag) else $error("reset flag not set");

  property p_pw_int;
    (pw_valid && en_q[EV_PW] && !wr_en) |=> (int_out && portwrite_in_int_out);
  endproperty
  a_pw_int: assert property (p_pw_int) else $error("port-write interrupt missing");

  property p_pw_flag;
    (pw_valid && cfg_wr && wr_data[CFG_PW_FLAG]) |=> portwrite_in_int_out;
  endproperty
  a_pw_flag: assert property (p_pw_flag) else $error("set lost to clear");

  sequence s_pw_read3;
    rd_en && addr == OFF_PW3 && !pw_valid;
  endsequence

  property p_capture;
    (pw_valid ##1 s_pw_read3) |=> (rd_data == $past(pw_payload[127:96], 2));
  endproperty
  a_capture: assert property (p_capture) else $error("payload word 3 wrong");

  property p_word0;
    pw_valid |=> (word_q[0] == $past(pw_payload[31:0]) && word_q[2] == $past(pw_payload[95:64]));
  endproperty
  a_word0: assert property (p_word0) else $error("payload split wrong");

  property p_div_upper;
    (rd_en && addr == OFF_DIV) |=> (rd_data[31:8] == 24'h000000 && rd_data[7:0] == tick_divider_value_q);
  endproperty
  a_div_upper: assert property (p_div_upper) else $error("divider upper bits set");

  property p_w1c;
    (cfg_wr && wr_data[CFG_PW_FLAG] && !pw_valid) |=> !portwrite_in_int_out;
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear");

  property p_w0_keep;
    (portwrite_in_int_out && cfg_wr && !wr_data[CFG_PW_FLAG]) |=> portwrite_in_int_out;
  endproperty
  a_w0_keep: assert property (p_w0_keep) else $error("write zero changed flag");

  // Level interrupt never lags an enable or flag change
  property p_int_level;
    int_out == |({mcast_int_out, rst_int_out, portwrite_in_int_out} & en_q);
  endproperty
  a_int_level: assert property (p_int_level) else $error("interrupt level wrong");

  property p_mcast_set;
    |(sym_valid & sym_mcast) |=> mcast_int_out;
  endproperty
  a_mcast_set: assert property (p_mcast_set) else $error("multicast flag not set");

  property p_rst_hold;
    (rst_int_out && !(cfg_wr && wr_data[CFG_RST_FLAG]) && !(wr_en && addr == OFF_IRQ_CLR)) |=> rst_int_out;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset flag dropped");

  property p_pw_set;
    pw_valid |=> portwrite_in_int_out;
  endproperty
  a_pw_set: assert property (p_pw_set) else $error("port-write flag not set");

  property p_pw_hold;
    (portwrite_in_int_out && !(cfg_wr && wr_data[CFG_PW_FLAG]) && !(wr_en && addr == OFF_IRQ_CLR)) |=> portwrite_in_int_out;
  endproperty
  a_pw_hold: assert property (p_pw_hold) else $error("port-write flag dropped");

  property p_word_hi;
    pw_valid |=> (word_q[1] == $past(pw_payload[63:32]) && word_q[3] == $past(pw_payload[127:96]));
  endproperty
  a_word_hi: assert property (p_word_hi) else $error("payload upper words wrong");

  property p_capt_ro;
    (wr_en && addr == OFF_PW0 && !pw_valid) |=> $stable(word_q[0]);
  endproperty
  a_capt_ro: assert property (p_capt_ro) else $error("capture word written");

  property p_div_write;
    (wr_en && addr == OFF_DIV) |=> (tick_divider_value_q == $past(wr_data[7:0]));
  endproperty
  a_div_write: assert property (p_div_write) else $error("divider not loaded");

  property p_clr_reg;
    (wr_en && addr == OFF_IRQ_CLR && wr_data[EV_PW] && !pw_valid) |=> !portwrite_in_int_out;
  endproperty
  a_clr_reg: assert property (p_clr_reg) else $error("clear register did not clear");

  property p_stat_read;
    (rd_en && addr == OFF_IRQ_STAT) |=> (rd_data == {29'h00000000, $past(flag_q)});
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("status read wrong");
endmodule

/* verification/link_partner.sv */
// Purpose: Far-end link model sending control symbols and port-writes
// Assumes: Bench calls its tasks; changes land just after a rising edge
// Notes: Released data lines show inverted last values, never stale ones; valid lines drop to 0
`timescale 1ns/1ns
module link_partner
(
  // Clock
  input wire logic clk_sys,
  // Symbol lanes and port-write
  output logic [3:0] sym_valid,
  output logic [3:0] sym_reset,
  output logic [3:0] sym_mcast,
  output logic pw_valid,
  output logic [127:0] pw_payload
);
  initial
  begin
    sym_valid = 4'h0;
    sym_reset = 4'h0;
    sym_mcast = 4'h0;
    pw_valid = 1'b0;
    pw_payload = '0;
  end
  task automatic sym(input int p, input logic r, input logic m);
    @(posedge clk_sys);
    sym_valid <= 4'h1 << p;
    sym_reset <= {3'h0, r} << p;
    sym_mcast <= {3'h0, m} << p;
  endtask
  task automatic idle();
    @(posedge clk_sys);
    sym_valid <= 4'h0;
    sym_reset <= ~sym_reset;
    sym_mcast <= ~sym_mcast;
    pw_valid <= 1'b0;
    pw_payload <= ~pw_payload;
  endtask
  task automatic pw(input logic [127:0] d);
    @(posedge clk_sys);
    pw_valid <= 1'b1;
    pw_payload <= d;
  endtask
endmodule

/* verification/tb_top.sv */
// Purpose: Self-checking bench for the link event bank
// Assumes: 25 MHz clock, register reads answer one cycle later
// Notes: Interrupt outputs are compared as one nibble
`timescale 1ns/1ns
module tb_top;
  import link_evt_pkg::*;
  logic clk_sys, rst_n, wr_en, rd_en, pw_valid;
  logic mcast_int_out, rst_int_out, portwrite_in_int_out, int_out, timer_tick;
  logic [19:0] addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0] sym_valid, sym_reset, sym_mcast;
  logic [127:0] pw_payload;
  logic [3:0] ints;
  int bad_count = 0;
  int cmp_count = 0;
  assign ints = {int_out, mcast_int_out, rst_int_out, portwrite_in_int_out};
  link_evt_bank u_link_evt_bank (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .sym_valid(sym_valid), .sym_reset(sym_reset),
    .sym_mcast(sym_mcast), .pw_valid(pw_valid), .pw_payload(pw_payload), .mcast_int_out(mcast_int_out),
    .rst_int_out(rst_int_out), .portwrite_in_int_out(portwrite_in_int_out), .int_out(int_out),
    .timer_tick(timer_tick));
  link_partner u_link_partner (.clk_sys(clk_sys), .sym_valid(sym_valid), .sym_reset(sym_reset),
    .sym_mcast(sym_mcast), .pw_valid(pw_valid), .pw_payload(pw_payload));
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [19:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    chk(rd_data, e);
  endtask
  task automatic t_regs();
    rd(OFF_DIV, 32'(DIV_RESET));
    for (int k = 0; k < NWORD; k++)
      rd(OFF_PW0 + 20'(4 * k), CAPT_RESET);
    rd(OFF_CFG, 32'h0);
    rd(20'h12030, 32'h0);
    wr(OFF_DIV, 32'hFFFFFF0F);
    rd(OFF_DIV, 32'h0000000F);
    $display("test regs done");
  endtask
  task automatic t_tick();
    int t0, t1;
    for (int d = 0; d < 4; d += 3)
    begin
      wr(OFF_DIV, 32'(d));
      t0 = -1;
      t1 = -1;
      for (int i = 0; i < 12; i++)
      begin
        @(posedge clk_sys);
        #1;
        if (timer_tick === 1'b1 && t0 < 0)
          t0 = i;
        else if (timer_tick === 1'b1 && t1 < 0)
          t1 = i;
      end
      chk(32'(t1 - t0), 32'(d + 1));
    end
    $display("test tick done");
  endtask
  task automatic t_pw();
    logic [127:0] pl;
    pl = 128'h0F1E2D3C_4B5A6978_8796A5B4_C3D2E1F0;
    wr(OFF_IRQ_EN, 32'h1);
    u_link_partner.pw(pl);
    u_link_partner.idle();
    #1;
    chk(32'(ints), 32'h9);
    for (int k = 0; k < NWORD; k++)
      rd(OFF_PW0 + 20'(4 * k), pl[32 * k +: 32]);
    wr(OFF_PW0, 32'hFFFFFFFF);
    rd(OFF_PW0, pl[31:0]);
    // A new port-write overwrites the capture, read back at once
    u_link_partner.pw(~pl);
    fork
      u_link_partner.idle();
      rd(OFF_PW3, ~pl[127:96]);
    join
    rd(OFF_CFG, 32'h3);
    wr(OFF_CFG, 32'h2);
    #1;
    chk(32'(ints), 32'h9);
    wr(OFF_IRQ_EN, 32'h0);
    #1;
    chk(32'(ints), 32'h1);
    wr(OFF_IRQ_CLR, 32'h1);
    #1;
    chk(32'(ints), 32'h0);
    // Set wins over a clear in the same cycle
    fork
      begin
        u_link_partner.pw(pl);
        u_link_partner.idle();
      end
      wr(OFF_CFG, 32'h3);
    join
    #1;
    chk(32'(ints), 32'h9);
    wr(OFF_CFG, 32'h1);
    #1;
    chk(32'(ints), 32'h0);
    $display("test pw done");
  endtask
  task automatic t_mc();
    wr(OFF_IRQ_EN, 32'h4);
    u_link_partner.sym(2, 1'b0, 1'b1);
    u_link_partner.idle();
    #1;
    chk(32'(ints), 32'hC);
    wr(OFF_IRQ_STAT, 32'h0);
    rd(OFF_IRQ_STAT, 32'h4);
    rd(OFF_CFG, 32'h30);
    rd(OFF_IRQ_EN, 32'h4);
    rd(OFF_IRQ_CLR, 32'h0);
    wr(OFF_CFG, 32'h10);
    #1;
    chk(32'(ints), 32'h0);
    $display("test mcast done");
  endtask
  task automatic t_rst();
    wr(OFF_IRQ_EN, 32'h2);
    // Fourth symbol is not a reset and breaks the run
    for (int i = 0; i < 7; i++)
      u_link_partner.sym(0, i != 3, 1'b0);
    u_link_partner.idle();
    repeat (2) @(posedge clk_sys);
    #1;
    chk(32'(ints), 32'h0);
    u_link_partner.sym(0, 1'b1, 1'b0);
    u_link_partner.idle();
    @(posedge clk_sys);
    #1;
    chk(32'(ints), 32'hA);
    wr(OFF_IRQ_CLR, 32'h2);
    #1;
    chk(32'(ints), 32'h0);
    // Eight resets in a row give two detections
    for (int i = 0; i < 8; i++)
      u_link_partner.sym(0, 1'b1, 1'b0);
    u_link_partner.idle();
    @(posedge clk_sys);
    #1;
    chk(32'(ints), 32'hA);
    $display("test reset run done");
  endtask
  initial
  begin
    rst_n = 1'b0;
    addr = 20'h0;
    wr_data = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_tick();
    t_pw();
    t_mc();
    t_rst();
    test_done();
  end
  initial
  begin
    #100000;
    bad_count++;
    test_done();
  end
endmodule
